// file: fbos_defs.svh
/*
 flash block op sequencer constants: status codes, field widths, timing counts.
 assumes inclusion by bare name from the design files.
*/
`ifndef FBOS_DEFS_SVH
`define FBOS_DEFS_SVH
`define FBOS_ST_OK 8'h00
`define FBOS_ST_PIN_LOW 8'h01
`define FBOS_ST_PARAM 8'h05
`define FBOS_ST_PROTECT 8'h10
`define FBOS_ST_ERASE_ERR 8'h1A
`define FBOS_ST_CHECK_ERR 8'h1B
`define FBOS_ST_INTERRUPTED 8'h1F
`define FBOS_BLOCK_W 16
`define FBOS_WORD_W 8
`define FBOS_WIDX_W 4
`define FBOS_WORDS 16
`define FBOS_BLOCK_COUNT 16'h0010
`define FBOS_LAST_WORD 4'hF
`define FBOS_ERASED 8'hFF
`define FBOS_MARGIN_OK_BIT 7
`define FBOS_INIT_CYCLES 8'h20
`endif

// file: fbos_pkg.sv
/*
 flash block op sequencer types: command encodings and sequencer states.
 assumes fbos_defs.svh for widths.
*/
package fbos_pkg;
   typedef enum logic [2:0] {
      FBOS_CMD_MODE = 3'h0,
      FBOS_CMD_BLANK = 3'h1,
      FBOS_CMD_ERASE = 3'h2,
      FBOS_CMD_VERIFY = 3'h3,
      FBOS_CMD_INIT = 3'h4,
      FBOS_CMD_INIT_RESUME = 3'h5
   } fbos_cmd_e;
   typedef enum logic [4:0] {
      FBOS_IDLE = 5'h01,
      FBOS_READ = 5'h02,
      FBOS_ERASE = 5'h04,
      FBOS_INIT = 5'h08,
      FBOS_DONE = 5'h10
   } fbos_state_e;
endpackage

// file: fbos_array.sv
/*
 fbos_array: small model of the flash array, one word per cell, registered read.
 assumes a single writer; erase writes the erased value, program is external.
*/
`timescale 1ns/1ns
`include "fbos_defs.svh"
module fbos_array (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic [`FBOS_BLOCK_W+`FBOS_WIDX_W-1:0] i_addr,
   input wire logic i_we,
   input wire logic [`FBOS_WORD_W-1:0] i_wdata,
   output logic [`FBOS_WORD_W-1:0] o_rdata
);
   localparam int DEPTH = 256;
   logic [`FBOS_WORD_W-1:0] mem_reg [DEPTH];
   logic [`FBOS_WORD_W-1:0] rdata_reg;
   logic [7:0] idx;
   assign idx = i_addr[7:0];
   assign o_rdata = rdata_reg;
   always_ff @(posedge i_clk) begin
      if (i_we) begin
         mem_reg[idx] <= i_wdata;
      end
      rdata_reg <= mem_reg[idx];
   end
endmodule

// file: fbos_top.sv
/*
 fbos_top: command sequencer for flash self-programming, one block per command.
 assumes the caller holds i_cmd_valid only while o_busy is low and the pin is asynchronous.
*/
// Summary of operation
// - mode check returns 00h when enable pin high, 01h when low.
// - no erase or write happens while the enable pin is low.
// - blank check scans one block and returns 00h when all cells erased.
// - blank check returns 1Bh when any cell is not erased.
// - out-of-range block gives 05h without touching the array.
// - user interrupt during a running operation aborts with 1Fh.
// - erase clears exactly one block and returns 00h on success.
// - erase of out-of-shield block, or of boot block while i_boot_rewrite_en is low, is refused with 10h.
// - an erase that fails while running returns 1Ah.
// - margin verify checks threshold margin bit per cell, not data equality.
// - margin verify returns 1Bh on failure and 00h on success.
`timescale 1ns/1ns
`include "fbos_defs.svh"
module fbos_top
   import fbos_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_cmd_valid,
   input wire logic [2:0] i_cmd,
   input wire logic [`FBOS_BLOCK_W-1:0] i_block,
   input wire logic i_flash_mode_enable_pin,
   input wire logic i_user_irq,
   input wire logic i_boot_rewrite_en,
   input wire logic [`FBOS_BLOCK_W-1:0] i_boot_last_block,
   input wire logic [`FBOS_BLOCK_W-1:0] i_shield_first,
   input wire logic [`FBOS_BLOCK_W-1:0] i_shield_last,
   input wire logic i_erase_fault,
   output logic o_busy,
   output logic o_done,
   output logic [`FBOS_WORD_W-1:0] o_status
);
   // ----------------------------------------------------------------
   // pin synchroniser
   // ----------------------------------------------------------------
   logic [2:0] pin_sync_reg;
   logic [2:0] pin_sync_next;
   logic pin_level_reg;
   logic pin_level_next;
   always_comb begin
      pin_sync_next = {pin_sync_reg[1:0], i_flash_mode_enable_pin};
      pin_level_next = pin_level_reg;
      if (pin_sync_reg[1] == pin_sync_reg[2]) begin
         pin_level_next = pin_sync_reg[2];
      end
   end
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         pin_sync_reg <= 3'h0;
         pin_level_reg <= 1'b0;
      end else begin
         pin_sync_reg <= pin_sync_next;
         pin_level_reg <= pin_level_next;
      end
   end

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   function automatic logic in_range(input logic [`FBOS_BLOCK_W-1:0] blk);
      in_range = (blk < `FBOS_BLOCK_COUNT);
   endfunction

   fbos_state_e state_reg, state_next;
   fbos_cmd_e cmd_reg, cmd_next;
   logic [`FBOS_BLOCK_W-1:0] block_reg, block_next;
   logic [`FBOS_WIDX_W-1:0] widx_reg, widx_next;
   logic bad_reg, bad_next;
   logic lag_reg, lag_next;
   logic [7:0] icnt_reg, icnt_next;
   logic busy_reg, busy_next;
   logic done_reg, done_next;
   logic [`FBOS_WORD_W-1:0] status_reg, status_next;
   logic mem_we;
   logic [`FBOS_BLOCK_W+`FBOS_WIDX_W-1:0] mem_addr;
   logic [`FBOS_WORD_W-1:0] mem_rdata;
   logic cell_bad;

   // margin judged on the threshold bit, not data compare
   assign cell_bad = (cmd_reg == FBOS_CMD_BLANK) ? (mem_rdata != `FBOS_ERASED)
                                                 : !mem_rdata[`FBOS_MARGIN_OK_BIT];

   always_comb begin
      state_next = state_reg;
      cmd_next = cmd_reg;
      block_next = block_reg;
      widx_next = widx_reg;
      bad_next = bad_reg;
      lag_next = 1'b0;
      icnt_next = icnt_reg;
      busy_next = busy_reg;
      done_next = 1'b0;
      status_next = status_reg;
      mem_we = 1'b0;
      case (state_reg)
         FBOS_IDLE: begin
            // a command is taken only while idle
            if (i_cmd_valid) begin
               cmd_next = fbos_cmd_e'(i_cmd);
               block_next = i_block;
               widx_next = '0;
               bad_next = 1'b0;
               icnt_next = `FBOS_INIT_CYCLES;
               busy_next = 1'b1;
               state_next = FBOS_DONE;
               case (fbos_cmd_e'(i_cmd))
                  FBOS_CMD_MODE: begin
                     status_next = pin_level_reg ? `FBOS_ST_OK : `FBOS_ST_PIN_LOW;
                  end
                  FBOS_CMD_BLANK, FBOS_CMD_VERIFY: begin
                     // range checked before the array is touched
                     if (!in_range(i_block)) begin
                        status_next = `FBOS_ST_PARAM;
                     end else begin
                        lag_next = 1'b1;
                        state_next = FBOS_READ;
                     end
                  end
                  FBOS_CMD_ERASE: begin
                     if (!in_range(i_block)) begin
                        status_next = `FBOS_ST_PARAM;
                     end else if ((!i_boot_rewrite_en && i_block <= i_boot_last_block) ||
                                  i_block < i_shield_first || i_block > i_shield_last) begin
                        status_next = `FBOS_ST_PROTECT;
                     // no erase with the enable pin low
                     end else if (!pin_level_reg) begin
                        status_next = `FBOS_ST_ERASE_ERR;
                     end else begin
                        state_next = FBOS_ERASE;
                     end
                  end
                  FBOS_CMD_INIT, FBOS_CMD_INIT_RESUME: begin
                     state_next = FBOS_INIT;
                  end
                  default: begin
                     status_next = `FBOS_ST_PARAM;
                  end
               endcase
            end
         end
         FBOS_READ: begin
            if (i_user_irq) begin
               status_next = `FBOS_ST_INTERRUPTED;
               state_next = FBOS_DONE;
            end else if (!lag_reg) begin
               // scan every cell of the block once
               widx_next = widx_reg + 1'b1;
               bad_next = bad_reg | cell_bad;
               if (widx_reg == `FBOS_LAST_WORD) begin
                  // any bad cell gives the check error
                  // verify result reported as 00h or 1Bh
                  status_next = (bad_reg | cell_bad) ? `FBOS_ST_CHECK_ERR : `FBOS_ST_OK;
                  state_next = FBOS_DONE;
               end
            end
         end
         FBOS_ERASE: begin
            if (i_user_irq) begin
               status_next = `FBOS_ST_INTERRUPTED;
               state_next = FBOS_DONE;
            // fault or pin drop during erase is an erase error
            end else if (i_erase_fault || !pin_level_reg) begin
               status_next = `FBOS_ST_ERASE_ERR;
               state_next = FBOS_DONE;
            end else begin
               mem_we = 1'b1;
               widx_next = widx_reg + 1'b1;
               if (widx_reg == `FBOS_LAST_WORD) begin
                  status_next = `FBOS_ST_OK;
                  state_next = FBOS_DONE;
               end
            end
         end
         FBOS_INIT: begin
            // initialisation is resumable; the count survives an abort
            if (i_user_irq) begin
               status_next = `FBOS_ST_INTERRUPTED;
               state_next = FBOS_DONE;
            end else if (icnt_reg == 8'h00) begin
               status_next = `FBOS_ST_OK;
               state_next = FBOS_DONE;
            end else begin
               icnt_next = icnt_reg - 8'h01;
            end
         end
         FBOS_DONE: begin
            busy_next = 1'b0;
            done_next = 1'b1;
            state_next = FBOS_IDLE;
         end
         default: begin
            state_next = FBOS_IDLE;
            busy_next = 1'b0;
         end
      endcase
      if (state_reg == FBOS_IDLE && i_cmd_valid && fbos_cmd_e'(i_cmd) == FBOS_CMD_INIT_RESUME) begin
         icnt_next = icnt_reg;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         state_reg <= FBOS_IDLE;
         cmd_reg <= FBOS_CMD_MODE;
         block_reg <= '0;
         widx_reg <= '0;
         bad_reg <= 1'b0;
         lag_reg <= 1'b0;
         icnt_reg <= `FBOS_INIT_CYCLES;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
         status_reg <= `FBOS_ST_OK;
      end else begin
         state_reg <= state_next;
         cmd_reg <= cmd_next;
         block_reg <= block_next;
         widx_reg <= widx_next;
         bad_reg <= bad_next;
         lag_reg <= lag_next;
         icnt_reg <= icnt_next;
         busy_reg <= busy_next;
         done_reg <= done_next;
         status_reg <= status_next;
      end
   end

   assign o_busy = busy_reg;
   assign o_done = done_reg;
   assign o_status = status_reg;

   // reads look one word ahead so the registered read data belong to widx_reg
   assign mem_addr = mem_we ? {block_reg, widx_reg} : {block_next, widx_next};

   fbos_array u_array (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_addr(mem_addr),
      .i_we(mem_we),
      .i_wdata(`FBOS_ERASED),
      .o_rdata(mem_rdata)
   );

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   sequence erase_running;
      state_reg == FBOS_ERASE;
   endsequence
   sequence done_pulse;
      done_reg ##1 !done_reg;
   endsequence

   mode_status_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      state_reg == FBOS_IDLE && i_cmd_valid && i_cmd == 3'h0 |=> ##1
      done_reg && status_reg == (pin_level_reg ? 8'h00 : 8'h01)) else $error("mode status wrong");
   no_erase_low_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      mem_we |-> pin_level_reg) else $error("array erased with pin low");
   range_param_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      state_reg == FBOS_IDLE && i_cmd_valid && i_cmd inside {3'h1, 3'h2, 3'h3} && i_block >= 16'h0010
      |=> state_reg == FBOS_DONE && status_reg == 8'h05) else $error("range error missing");
   irq_abort_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      state_reg inside {FBOS_READ, FBOS_ERASE} && i_user_irq |=> status_reg == 8'h1F ##1 done_reg)
      else $error("interrupt not reported");
   erase_len_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      $rose(state_reg == FBOS_ERASE) |-> ##[1:16] state_reg != FBOS_ERASE)
      else $error("erase overran block");
   protect_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      state_reg == FBOS_IDLE && i_cmd_valid && i_cmd == 3'h2 && i_block < 16'h0010 &&
      (i_block < i_shield_first || i_block > i_shield_last) |=> status_reg == 8'h10 && !mem_we)
      else $error("protect not refused");
   erase_fault_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      erase_running and (!i_user_irq && i_erase_fault) |=> status_reg == 8'h1A)
      else $error("erase fault not reported");
   check_result_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      state_reg == FBOS_READ && state_next == FBOS_DONE && !i_user_irq |=>
      status_reg inside {8'h00, 8'h1B}) else $error("check status out of set");
   one_cmd_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      busy_reg |=> $stable(block_reg)) else $error("command taken while busy");
   done_once_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      $rose(done_reg) |-> done_pulse and $past(state_reg) == FBOS_DONE) else $error("done not single");
endmodule

// file: fbos_cpu_model.sv
/*
 fbos_cpu_model: firmware side of the sequencer, one command at a time, waits for done.
 assumes the bench drives the sideband pins and calls these tasks.
*/
`timescale 1ns/1ns
`include "fbos_defs.svh"
module fbos_cpu_model (
   input wire logic i_clk,
   input wire logic i_done,
   input wire logic [`FBOS_WORD_W-1:0] i_status,
   output logic o_cmd_valid,
   output logic [2:0] o_cmd,
   output logic [`FBOS_BLOCK_W-1:0] o_block
);
   int lost = 0;
   initial begin
      o_cmd_valid = 1'b0;
      o_cmd = 3'h0;
      o_block = 16'h0000;
   end
   // --------------------------------
   // command issue
   // --------------------------------
   task automatic issue(input logic [2:0] c, input logic [15:0] b, output logic [7:0] st);
      int n;
      n = 0;
      // skip the done cycle, although the sequencer is already idle there and would take a request
      @(negedge i_clk);
      o_cmd_valid = 1'b1;
      o_cmd = c;
      o_block = b;
      @(negedge i_clk);
      o_cmd_valid = 1'b0;
      // released lines scrambled so a late sample cannot pass by luck
      o_cmd = ~c;
      o_block = ~b;
      while (i_done !== 1'b1 && n < 100) begin
         @(negedge i_clk);
         n++;
      end
      if (n >= 100)
         lost++;
      st = i_status;
   endtask
   task automatic run_init(output logic [7:0] st, output int tries);
      tries = 0;
      issue(3'h4, 16'h0000, st);
      while (st === 8'h1F && tries < 20) begin
         issue(3'h5, 16'h0000, st);
         tries++;
      end
   endtask
   task automatic check_block(input logic [15:0] b, output logic [7:0] e, output logic [7:0] bl,
                              output logic [7:0] v);
      issue(3'h2, b, e);
      issue(3'h1, b, bl);
      issue(3'h3, b, v);
   endtask
endmodule

// file: flash_block_op_sequencer_bench.sv
/*
 flash_block_op_sequencer_bench: self-checking bench, status compared with a behavioural model.
 assumes fbos_top, fbos_cpu_model and the package are compiled first.
*/
`timescale 1ns/1ns
module flash_block_op_sequencer_bench;
   import fbos_pkg::*;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic cmd_valid, busy, done;
   logic pin = 1'b1, irq = 1'b0, bren = 1'b0, fault = 1'b0;
   logic [2:0] cmd;
   logic [15:0] blk;
   logic [15:0] bootlast = 16'h0000, sf = 16'h0001, sl = 16'h000E;
   logic [7:0] status, st, e, bl, v;
   logic [15:0] seed = 16'h9DFC;
   int fail_count = 0, compares = 0, tries;
   bit erased [16];
   always #4 clk = ~clk;
   fbos_top uut (.i_clk(clk), .i_resetn(resetn), .i_cmd_valid(cmd_valid), .i_cmd(cmd), .i_block(blk),
      .i_flash_mode_enable_pin(pin), .i_user_irq(irq), .i_boot_rewrite_en(bren),
      .i_boot_last_block(bootlast), .i_shield_first(sf), .i_shield_last(sl), .i_erase_fault(fault),
      .o_busy(busy), .o_done(done), .o_status(status));
   fbos_cpu_model cpu (.i_clk(clk), .i_done(done), .i_status(status), .o_cmd_valid(cmd_valid),
      .o_cmd(cmd), .o_block(blk));
   // --------------------------------
   // model and checks
   // --------------------------------
   function automatic logic [7:0] expect_st(input logic [2:0] c, input logic [15:0] b);
      if (c == 3'h0)
         return pin ? 8'h00 : 8'h01;
      if (c > 3'h5 || (c inside {3'h1, 3'h2, 3'h3} && b >= 16'h0010))
         return 8'h05;
      if (c == 3'h1 || c == 3'h3)
         return erased[b[3:0]] ? 8'h00 : 8'h1B;
      if (c == 3'h2 && ((!bren && b <= bootlast) || b < sf || b > sl))
         return 8'h10;
      if (c == 3'h2 && (!pin || fault))
         return 8'h1A;
      return 8'h00;
   endfunction
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t status %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic run(input logic [2:0] c, input logic [15:0] b);
      logic [7:0] x;
      logic [7:0] r;
      x = expect_st(c, b);
      cpu.issue(c, b, r);
      check(r, x);
      if (c == 3'h2 && x == 8'h00)
         erased[b[3:0]] = 1'b1;
   endtask
   // abort lands mid-operation, well before the shortest scan ends
   task automatic irq_case(input logic [2:0] c, input logic [15:0] b);
      logic [7:0] r;
      fork
         cpu.issue(c, b, r);
         begin
            repeat (6) @(negedge clk);
            check({7'h00, busy}, 8'h01);
            irq = 1'b1;
            repeat (3) @(negedge clk);
            irq = 1'b0;
         end
      join
      check(r, 8'h1F);
      check({7'h00, busy}, 8'h00);
   endtask
   task automatic print_verdict();
      if (fail_count == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #200000;
      fail_count++;
      print_verdict();
   end
   // --------------------------------
   // scenarios
   // --------------------------------
   initial begin
      repeat (8) @(negedge clk);
      resetn = 1'b1;
      repeat (6) @(negedge clk);
      run(3'h0, 16'h0000);
      run(3'h2, 16'h0000);
      run(3'h2, 16'h000F);
      for (int c = 1; c < 4; c++) begin
         run(c[2:0], 16'h0010);
         run(c[2:0], 16'hFFFF);
      end
      run(3'h6, 16'h0000);
      run(3'h7, 16'h0000);
      for (int b = 1; b < 15; b++) begin
         e = expect_st(3'h2, b[15:0]);
         cpu.check_block(b[15:0], st, bl, v);
         check(st, e);
         erased[b] = 1'b1;
         check(bl, 8'h00);
         check(v, 8'h00);
      end
      bren = 1'b1;
      sf = 16'h0000;
      sl = 16'h000F;
      run(3'h2, 16'h0000);
      run(3'h2, 16'h000F);
      pin = 1'b0;
      repeat (8) @(negedge clk);
      run(3'h0, 16'h0000);
      run(3'h2, 16'h0003);
      pin = 1'b1;
      repeat (8) @(negedge clk);
      fault = 1'b1;
      run(3'h2, 16'h0004);
      fault = 1'b0;
      for (int c = 1; c < 4; c++)
         irq_case(c[2:0], 16'h0005);
      fork
         cpu.run_init(st, tries);
         begin
            repeat (10) @(negedge clk);
            irq = 1'b1;
            repeat (3) @(negedge clk);
            irq = 1'b0;
         end
      join
      check(st, 8'h00);
      check(tries[7:0], 8'h01);
      // every block is erased now, so blank and verify must report clean on in-range blocks 0 to 15
      for (int i = 0; i < 40; i++) begin
         seed = lfsr_next(seed);
         fault = seed[12] & seed[13];
         run({1'b0, seed[1:0]}, {11'h000, seed[8:4]});
      end
      fault = 1'b0;
      check(cpu.lost[7:0], 8'h00);
      print_verdict();
   end
endmodule
